// ===== dv/tmr_timer8_bench.sv
`timescale 1ns/1ns
module tmr_timer8_bench;
	logic        pclk = 0, presetn = 0, ce = 1, gie = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pin = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, err;
	logic        ack_a = 0, ack_o = 0, ack_b = 0;
	logic        irq_a, irq_o, irq_b, wa, oea, wb, oeb;
	logic [7:0]  om_v [4] = '{8'h40, 8'h80, 8'hC0, 8'h40};
	logic        ex_v [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int          dv [4] = '{8, 64, 256, 1024};
	int          fail_count = 0, num_checks = 0, i;

	always #5 pclk = ~pclk;

	tmr_timer8 dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.global_irq_en(gie), .vec_ack_cmp_a(ack_a),
		.vec_ack_ovf(ack_o), .vec_ack_cmp_b(ack_b),
		.irq_cmp_a(irq_a), .irq_ovf(irq_o), .irq_cmp_b(irq_b),
		.ext_count_pin(pin), .wave_out_a(wa), .wave_oe_a(oea),
		.wave_out_b(wb), .wave_oe_b(oeb));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// request held until pready is seen at an edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers is a failure, not a silent return
		if (pready !== 1'b1)
			fail_count++;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, {24'h0, e});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// whole run is well under 20k cycles
	initial begin
		#300000;
		fail_count++;
		print_verdict;
	end

	initial begin
		cyc(10);
		presetn <= 1'b1;
		for (i = 0; i < 7; i++) rd(8'(4 * i), 8'h00);
		rd(8'h1C, 8'h00);
		chk(err, 1'b1);
		wr(tmr_pkg::OFS_CTL_B, 8'hF8);
		rd(tmr_pkg::OFS_CTL_B, 8'h08);
		wr(tmr_pkg::OFS_CTL_B, 8'h00);
		wr(tmr_pkg::OFS_MASK, 8'hFF);
		rd(tmr_pkg::OFS_MASK, 8'h07);
		wr(tmr_pkg::OFS_MASK, 8'h00);
		wr(tmr_pkg::OFS_COUNT, 8'h5A);
		cyc(5);
		rd(tmr_pkg::OFS_COUNT, 8'h5A);
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			wr(tmr_pkg::OFS_CTL_A, om_v[i]);
			wr(tmr_pkg::OFS_CTL_B, 8'h80);
			cyc(2);
			chk(wa, ex_v[i]);
			chk(oea, 1'b1);
		end
		wr(tmr_pkg::OFS_CTL_A, 8'h30);
		wr(tmr_pkg::OFS_CTL_B, 8'h40);
		cyc(2);
		chk(wb, 1'b1);
		chk(oeb, 1'b1);
		rd(tmr_pkg::OFS_FLAGS, 8'h00);
		rd(tmr_pkg::OFS_COUNT, 8'h5A);
		wr(tmr_pkg::OFS_CTL_A, 8'h00);
		cyc(2);
		chk(oea, 1'b0);
		chk(oeb, 1'b0);
		// fast pwm: the force must be ignored
		wr(tmr_pkg::OFS_CTL_A, 8'hC3);
		wr(tmr_pkg::OFS_CTL_B, 8'h80);
		cyc(2);
		chk(wa, 1'b0);
		wr(tmr_pkg::OFS_CTL_A, 8'h00);
		$display("test force done");
		wr(tmr_pkg::OFS_CMP_A, 8'h40);
		wr(tmr_pkg::OFS_CMP_B, 8'h00);
		wr(tmr_pkg::OFS_MASK, 8'h01);
		gie <= 1'b1;
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		wr(tmr_pkg::OFS_CTL_B, 8'h01);
		for (i = 0; i < 200 && irq_a !== 1'b1; i++) cyc(1);
		chk(irq_a, 1'b1);
		wr(tmr_pkg::OFS_CTL_B, 8'h00);
		// compare b at 0 is masked on the first tick after the count write
		rd(tmr_pkg::OFS_FLAGS, 8'h01);
		wr(tmr_pkg::OFS_FLAGS, 8'h01);
		rd(tmr_pkg::OFS_FLAGS, 8'h00);
		chk(irq_a, 1'b0);
		$display("test match done");
		wr(tmr_pkg::OFS_MASK, 8'h06);
		gie <= 1'b0;
		wr(tmr_pkg::OFS_COUNT, 8'hF0);
		wr(tmr_pkg::OFS_CTL_B, 8'h01);
		cyc(40);
		wr(tmr_pkg::OFS_CTL_B, 8'h00);
		chk({irq_o, irq_b}, 2'b00);
		rd(tmr_pkg::OFS_FLAGS, 8'h06);
		gie <= 1'b1;
		cyc(3);
		chk({irq_o, irq_b}, 2'b11);
		ack_o <= 1'b1;
		cyc(1);
		ack_o <= 1'b0;
		ack_b <= 1'b1;
		cyc(1);
		ack_b <= 1'b0;
		cyc(3);
		chk({irq_o, irq_b}, 2'b00);
		rd(tmr_pkg::OFS_FLAGS, 8'h00);
		$display("test overflow done");
		// phase correct: no overflow at the peak, only at bottom
		wr(tmr_pkg::OFS_CTL_A, 8'h01);
		wr(tmr_pkg::OFS_COUNT, 8'hF0);
		wr(tmr_pkg::OFS_CTL_B, 8'h01);
		cyc(20);
		wr(tmr_pkg::OFS_CTL_B, 8'h00);
		rd(tmr_pkg::OFS_FLAGS, 8'h00);
		wr(tmr_pkg::OFS_CTL_B, 8'h01);
		cyc(270);
		wr(tmr_pkg::OFS_CTL_B, 8'h00);
		rd(tmr_pkg::OFS_FLAGS, 8'h07);
		wr(tmr_pkg::OFS_FLAGS, 8'h07);
		// clear on match: wraps at compare a, so max is never reached
		wr(tmr_pkg::OFS_CTL_A, 8'h02);
		wr(tmr_pkg::OFS_CMP_A, 8'h10);
		wr(tmr_pkg::OFS_COUNT, 8'h00);
		wr(tmr_pkg::OFS_CTL_B, 8'h01);
		cyc(40);
		wr(tmr_pkg::OFS_CTL_B, 8'h00);
		rd(tmr_pkg::OFS_FLAGS, 8'h05);
		wr(tmr_pkg::OFS_FLAGS, 8'h07);
		wr(tmr_pkg::OFS_CTL_A, 8'h00);
		$display("test modes done");
		for (i = 0; i < 4; i++) begin
			wr(tmr_pkg::OFS_COUNT, 8'h00);
			wr(tmr_pkg::OFS_CTL_B, 8'(i + 2));
			cyc(4 * dv[i]);
			wr(tmr_pkg::OFS_CTL_B, 8'h00);
			bus(1'b0, tmr_pkg::OFS_COUNT, 32'h0);
			// prescaler phase is free running, so allow a window
			chk(32'(q inside {[3:5]}), 32'h1);
		end
		$display("test prescaler done");
		for (i = 0; i < 2; i++) begin
			wr(tmr_pkg::OFS_COUNT, 8'h00);
			wr(tmr_pkg::OFS_CTL_B, (i == 0) ? 8'h07 : 8'h06);
			repeat (3) begin
				pin <= 1'b1;
				cyc(3);
				pin <= 1'b0;
				cyc(3);
			end
			cyc(4);
			wr(tmr_pkg::OFS_CTL_B, 8'h00);
			rd(tmr_pkg::OFS_COUNT, 8'h03);
		end
		$display("test pin done");
		print_verdict;
	end
endmodule // tmr_timer8_bench

// ===== dv/tmr_timer8_chk.sv
`timescale 1ns/1ns
module tmr_timer8_chk (
	// clock and reset
	input wire logic        pclk, presetn, ce,
	// apb
	input wire logic        psel, penable, pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic        pready, pslverr,
	// cpu side
	input wire logic        global_irq_en,
	input wire logic        vec_ack_cmp_a, vec_ack_ovf, vec_ack_cmp_b,
	input wire logic        irq_cmp_a, irq_ovf, irq_cmp_b,
	// pins
	input wire logic        ext_count_pin,
	input wire logic        wave_out_a, wave_oe_a, wave_out_b, wave_oe_b
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = pready && !pwrite;

	chk_irq_a_gate: assert property (
		irq_cmp_a && $past(ce) |-> $past(global_irq_en))
		else $error("compare a request without global enable");
	chk_irq_o_gate: assert property (
		irq_ovf && $past(ce) |-> $past(global_irq_en))
		else $error("overflow request without global enable");
	chk_irq_b_gate: assert property (
		irq_cmp_b && $past(ce) |-> $past(global_irq_en))
		else $error("compare b request without global enable");
	chk_ctlb_rd_zero: assert property (
		rd && paddr == tmr_pkg::OFS_CTL_B |-> prdata[7:4] == 4'h0)
		else $error("control b strobe or reserved bits read nonzero");
	chk_mask_rd_zero: assert property (
		rd && paddr == tmr_pkg::OFS_MASK |-> prdata[7:3] == 5'h00)
		else $error("mask reserved bits read nonzero");
	chk_flag_rd_zero: assert property (
		rd && paddr == tmr_pkg::OFS_FLAGS |-> prdata[7:3] == 5'h00)
		else $error("flag reserved bits read nonzero");
	chk_rd_upper: assert property (
		pready |-> prdata[31:8] == 24'h000000)
		else $error("read data above the byte not zero");
	chk_one_wait: assert property (
		psel && $rose(penable) && ce |-> !pready ##1 (pready || !$past(ce)))
		else $error("access phase not exactly one wait state");
endmodule // tmr_timer8_chk

bind tmr_timer8 tmr_timer8_chk u_chk (.pclk, .presetn, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.global_irq_en, .vec_ack_cmp_a, .vec_ack_ovf, .vec_ack_cmp_b,
	.irq_cmp_a, .irq_ovf, .irq_cmp_b, .ext_count_pin, .wave_out_a,
	.wave_oe_a, .wave_out_b, .wave_oe_b);

// ===== logic/tmr_clk_src.sv
`timescale 1ns/1ns
module tmr_clk_src (
	// clock and reset
	input  wire  logic       pclk,
	input  wire  logic       presetn,
	input  wire  logic       ce,
	// selection and pin
	input  wire  logic [2:0] clk_sel,
	input  wire  logic       ext_count_pin,
	// one-cycle count enable
	output logic             tick
);

	logic [tmr_pkg::PRE_W-1:0] pre;
	logic                      pin_q;
	logic                      rise;
	logic                      fall;
	logic                      next_tick;

	// free running: taps are not aligned to the select write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre   <= tmr_pkg::PRE_RESET;
			pin_q <= 1'b0;
		end else if (ce) begin
			pre   <= pre + tmr_pkg::PRE_ONE;
			pin_q <= ext_count_pin;
		end
	end

	// pin is sampled even while driven by its own port as output
	assign rise = ext_count_pin & ~pin_q;
	assign fall = ~ext_count_pin & pin_q;

	always_comb begin
		case (clk_sel)
			tmr_pkg::CS_STOP:  next_tick = 1'b0;
			tmr_pkg::CS_DIV1:  next_tick = 1'b1;
			tmr_pkg::CS_DIV8:  next_tick = (pre & tmr_pkg::TAP_8) == tmr_pkg::TAP_8;
			tmr_pkg::CS_DIV64: next_tick = (pre & tmr_pkg::TAP_64) == tmr_pkg::TAP_64;
			tmr_pkg::CS_DV256: next_tick = (pre & tmr_pkg::TAP_256) == tmr_pkg::TAP_256;
			tmr_pkg::CS_DV1K:  next_tick = (pre & tmr_pkg::TAP_1024) == tmr_pkg::TAP_1024;
			tmr_pkg::CS_EXT_F: next_tick = fall;
			tmr_pkg::CS_EXT_R: next_tick = rise;
			default:           next_tick = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick <= 1'b0;
		else if (ce)
			tick <= next_tick;
	end

endmodule // tmr_clk_src

// ===== logic/tmr_pkg.sv
package tmr_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTL_A  = 8'h00;
	localparam logic [7:0] OFS_CTL_B  = 8'h04;
	localparam logic [7:0] OFS_COUNT  = 8'h08;
	localparam logic [7:0] OFS_CMP_A  = 8'h0C;
	localparam logic [7:0] OFS_CMP_B  = 8'h10;
	localparam logic [7:0] OFS_MASK   = 8'h14;
	localparam logic [7:0] OFS_FLAGS  = 8'h18;

	// control b field positions
	localparam int B_FORCE_A = 7;
	localparam int B_FORCE_B = 6;
	localparam int B_WAVE_HI = 3;
	localparam int B_CSEL_LO = 0;

	// control a field positions
	localparam int A_OUT_A_LO = 6;
	localparam int A_OUT_B_LO = 4;
	localparam int A_WAVE_LO  = 0;

	// mask and flag bit positions
	localparam int IRQ_CMP_B = 2;
	localparam int IRQ_OVF   = 1;
	localparam int IRQ_CMP_A = 0;

	// counter limits
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_ONE    = 8'h01;
	localparam logic [7:0] RST_BYTE   = 8'h00;

	// clock select codes
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIV1  = 3'h1;
	localparam logic [2:0] CS_DIV8  = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DV256 = 3'h4;
	localparam logic [2:0] CS_DV1K  = 3'h5;
	localparam logic [2:0] CS_EXT_F = 3'h6;
	localparam logic [2:0] CS_EXT_R = 3'h7;

	// prescaler width and tap masks
	localparam int         PRE_W     = 10;
	localparam logic [9:0] TAP_8     = 10'h007;
	localparam logic [9:0] TAP_64    = 10'h03F;
	localparam logic [9:0] TAP_256   = 10'h0FF;
	localparam logic [9:0] TAP_1024  = 10'h3FF;
	localparam logic [9:0] PRE_ONE   = 10'h001;
	localparam logic [9:0] PRE_RESET = 10'h000;

	// waveform mode codes {wave_mode_hi, wave_mode_lo}
	localparam logic [2:0] WM_CTC     = 3'h2;
	localparam logic [2:0] WM_PC_OCRA = 3'h5;
	localparam logic [2:0] WM_FP_OCRA = 3'h7;
	localparam logic [1:0] WL_NONPWM  = 2'h0;
	localparam logic [1:0] WL_PHASE   = 2'h1;
	localparam logic [1:0] WL_CTC     = 2'h2;
	localparam logic [1:0] WL_FAST    = 2'h3;

	// compare output mode codes
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	typedef enum logic [1:0] {
		TMR_NONPWM,
		TMR_FAST,
		TMR_PHASE
	} tmr_kind_e;

	typedef struct packed {
		logic [1:0] out_mode_a;
		logic [1:0] out_mode_b;
		logic [1:0] wave_mode_lo;
	} tmr_ctl_a_s;

	typedef struct packed {
		logic       wave_mode_hi;
		logic [2:0] clk_sel;
	} tmr_ctl_b_s;

endpackage

// ===== logic/tmr_timer8.sv
// Function
// - force bit A acts only in non-PWM waveform modes.
// - force A applies an immediate match using current out_mode_a.
// - force B applies an immediate match using current out_mode_b.
// - forced match sets no flag, no interrupt, no counter clear.
// - both force bits are strobes and read back zero.
// - control b bits 5:4, mask bit 4, flag bit 4 read zero.
// - clk_sel codes 0..5: stop, io_clock, /8, /64, /256, /1024.
// - clk_sel 6 counts pin falling edges, 7 rising edges.
// - pin edges count even when the pin is an output.
// - counter register readable and writable by software.
// - counter write blocks compare match on next timer clock.
// - compare registers continuously compared, drive pin and interrupt.
// - mask bits: 2 compare B, 1 overflow, 0 compare A, gated globally.
// - compare B match sets cmp_b_flag.
// - compare A match sets cmp_a_flag.
// - counter overflow sets ovf_flag, point depends on waveform mode.
// - flags clear on vector execution or by writing one.
// - request needs flag, enable and global interrupt bit all set.
// - mode picks top and overflow point: max, bottom or top.
// - non-PWM out modes: off, toggle, clear, set on match.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module tmr_timer8 (
	// clock and reset
	input  wire  logic        pclk,
	input  wire  logic        presetn,
	input  wire  logic        ce,
	// apb slave
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [7:0]  paddr,
	input  wire  logic [31:0] pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// cpu side
	input  wire  logic        global_irq_en,
	input  wire  logic        vec_ack_cmp_a,
	input  wire  logic        vec_ack_ovf,
	input  wire  logic        vec_ack_cmp_b,
	output logic              irq_cmp_a,
	output logic              irq_ovf,
	output logic              irq_cmp_b,
	// pins
	input  wire  logic        ext_count_pin,
	output logic              wave_out_a,
	output logic              wave_oe_a,
	output logic              wave_out_b,
	output logic              wave_oe_b
);

	tmr_pkg::tmr_ctl_a_s ctl_a;
	tmr_pkg::tmr_ctl_b_s ctl_b;
	tmr_pkg::tmr_kind_e  kind;
	logic [7:0]          count;
	logic [7:0]          cmp_a;
	logic [7:0]          cmp_b;
	logic [2:0]          irq_mask;
	logic [2:0]          flags;
	logic                up;
	logic                block;
	logic                tick;

	// bus decode
	wire       acc      = psel & penable & pready;
	wire       wr       = acc & pwrite;
	wire       wr_ctl_a = wr & (paddr == tmr_pkg::OFS_CTL_A);
	wire       wr_ctl_b = wr & (paddr == tmr_pkg::OFS_CTL_B);
	wire       wr_count = wr & (paddr == tmr_pkg::OFS_COUNT);
	wire       wr_cmp_a = wr & (paddr == tmr_pkg::OFS_CMP_A);
	wire       wr_cmp_b = wr & (paddr == tmr_pkg::OFS_CMP_B);
	wire       wr_mask  = wr & (paddr == tmr_pkg::OFS_MASK);
	wire       wr_flags = wr & (paddr == tmr_pkg::OFS_FLAGS);
	wire       mapped   = (paddr == tmr_pkg::OFS_CTL_A)
	                    | (paddr == tmr_pkg::OFS_CTL_B)
	                    | (paddr == tmr_pkg::OFS_COUNT)
	                    | (paddr == tmr_pkg::OFS_CMP_A)
	                    | (paddr == tmr_pkg::OFS_CMP_B)
	                    | (paddr == tmr_pkg::OFS_MASK)
	                    | (paddr == tmr_pkg::OFS_FLAGS);

	// mode decode
	wire [2:0] mode     = {ctl_b.wave_mode_hi, ctl_a.wave_mode_lo};
	wire       is_pwm   = ctl_a.wave_mode_lo == tmr_pkg::WL_PHASE
	                    | ctl_a.wave_mode_lo == tmr_pkg::WL_FAST;
	wire       is_phase = ctl_a.wave_mode_lo == tmr_pkg::WL_PHASE;
	wire       ocra_top = mode == tmr_pkg::WM_CTC
	                    | mode == tmr_pkg::WM_PC_OCRA
	                    | mode == tmr_pkg::WM_FP_OCRA;
	wire [7:0] top_val  = ocra_top ? cmp_a : tmr_pkg::CNT_MAX;
	wire       at_top   = count == top_val;
	wire       at_bot   = count == tmr_pkg::CNT_BOTTOM;

	assign kind = !is_pwm ? tmr_pkg::TMR_NONPWM :
	              is_phase ? tmr_pkg::TMR_PHASE : tmr_pkg::TMR_FAST;

	// events on a timer clock; a count write masks the next match
	wire match_a = tick & ~block & (count == cmp_a);
	wire match_b = tick & ~block & (count == cmp_b);
	wire ovf_evt = tick & (is_phase ? at_bot :
	               (mode == tmr_pkg::WM_FP_OCRA ? at_top
	                : count == tmr_pkg::CNT_MAX));

	// forced matches reach the waveform only, never flags or counter
	wire force_a = wr_ctl_b & pwdata[tmr_pkg::B_FORCE_A] & ~is_pwm;
	wire force_b = wr_ctl_b & pwdata[tmr_pkg::B_FORCE_B] & ~is_pwm;

	// counter sequence
	wire [7:0] cnt_up = count + tmr_pkg::CNT_ONE;
	wire [7:0] cnt_dn = count - tmr_pkg::CNT_ONE;
	wire       turn   = up ? at_top : at_bot;
	wire       next_up = is_phase ? (turn ? ~up : up) : 1'b1;
	wire [7:0] next_count = is_phase ? (next_up ? cnt_up : cnt_dn)
	                      : (at_top ? tmr_pkg::CNT_BOTTOM : cnt_up);

	// waveform output update shared by both channels
	function automatic logic wave_next(
		input logic               cur,
		input logic [1:0]         om,
		input tmr_pkg::tmr_kind_e k,
		input logic               tgl_ok,
		input logic               match,
		input logic               top_hit,
		input logic               top_eq,
		input logic               dir_up
	);
		logic nv;
		nv = cur;
		case (k)
			tmr_pkg::TMR_NONPWM: begin
				if (match) begin
					case (om)
						tmr_pkg::OM_TOGGLE: nv = ~cur;
						tmr_pkg::OM_CLEAR:  nv = 1'b0;
						tmr_pkg::OM_SET:    nv = 1'b1;
						default:            nv = cur;
					endcase
				end
			end
			tmr_pkg::TMR_FAST: begin
				// compare equal to top: the top action wins
				if (om[1] && top_hit)
					nv = ~om[0];
				else if (match && om[1] && !top_eq)
					nv = om[0];
				else if (match && om == tmr_pkg::OM_TOGGLE && tgl_ok)
					nv = ~cur;
			end
			tmr_pkg::TMR_PHASE: begin
				if (match && om[1])
					nv = dir_up ? om[0] : ~om[0];
				else if (match && om == tmr_pkg::OM_TOGGLE && tgl_ok)
					nv = ~cur;
			end
			default: nv = cur;
		endcase
		return nv;
	endfunction

	wire top_tick = tick & at_top;
	wire next_wa  = force_a
	              ? wave_next(wave_out_a, ctl_a.out_mode_a,
	                          tmr_pkg::TMR_NONPWM, 1'b0, 1'b1,
	                          1'b0, 1'b0, up)
	              : wave_next(wave_out_a, ctl_a.out_mode_a, kind,
	                          ctl_b.wave_mode_hi, match_a, top_tick,
	                          cmp_a == top_val, up);
	wire next_wb  = force_b
	              ? wave_next(wave_out_b, ctl_a.out_mode_b,
	                          tmr_pkg::TMR_NONPWM, 1'b0, 1'b1,
	                          1'b0, 1'b0, up)
	              : wave_next(wave_out_b, ctl_a.out_mode_b, kind,
	                          1'b0, match_b, top_tick,
	                          cmp_b == top_val, up);

	// flags: hardware set beats any clear in the same cycle
	wire [2:0] set_f = {match_b, ovf_evt, match_a};
	wire [2:0] ack_f = {vec_ack_cmp_b, vec_ack_ovf, vec_ack_cmp_a};
	wire [2:0] wclr  = wr_flags ? pwdata[2:0] : 3'h0;
	wire [2:0] next_flags = set_f | (flags & ~(ack_f | wclr));
	wire [2:0] irq_req    = flags & irq_mask
	                      & {3{global_irq_en}};

	// read mux; force strobes and reserved bits read zero
	wire [7:0] rd_byte =
		(paddr == tmr_pkg::OFS_CTL_A) ? {ctl_a.out_mode_a,
		                                 ctl_a.out_mode_b, 2'h0,
		                                 ctl_a.wave_mode_lo} :
		(paddr == tmr_pkg::OFS_CTL_B) ? {4'h0, ctl_b.wave_mode_hi,
		                                 ctl_b.clk_sel} :
		(paddr == tmr_pkg::OFS_COUNT) ? count :
		(paddr == tmr_pkg::OFS_CMP_A) ? cmp_a :
		(paddr == tmr_pkg::OFS_CMP_B) ? cmp_b :
		(paddr == tmr_pkg::OFS_MASK)  ? {5'h00, irq_mask} :
		(paddr == tmr_pkg::OFS_FLAGS) ? {5'h00, flags} :
		tmr_pkg::RST_BYTE;

	tmr_clk_src u_clk_src (
		.pclk          (pclk),
		.presetn       (presetn),
		.ce            (ce),
		.clk_sel       (ctl_b.clk_sel),
		.ext_count_pin (ext_count_pin),
		.tick          (tick)
	);

	// bus answer: one wait state, then pready for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata  <= {24'h00_0000, rd_byte};
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_a    <= '0;
			ctl_b    <= '0;
			cmp_a    <= tmr_pkg::RST_BYTE;
			cmp_b    <= tmr_pkg::RST_BYTE;
			irq_mask <= 3'h0;
		end else if (ce) begin
			if (wr_ctl_a)
				ctl_a <= {pwdata[tmr_pkg::A_OUT_A_LO +: 2],
				          pwdata[tmr_pkg::A_OUT_B_LO +: 2],
				          pwdata[tmr_pkg::A_WAVE_LO +: 2]};
			if (wr_ctl_b)
				ctl_b <= {pwdata[tmr_pkg::B_WAVE_HI],
				          pwdata[tmr_pkg::B_CSEL_LO +: 3]};
			if (wr_cmp_a)
				cmp_a <= pwdata[7:0];
			if (wr_cmp_b)
				cmp_b <= pwdata[7:0];
			if (wr_mask)
				irq_mask <= pwdata[2:0];
		end
	end

	// counter; a software write wins over a tick in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= tmr_pkg::RST_BYTE;
			up    <= 1'b1;
			block <= 1'b0;
		end else if (ce) begin
			if (wr_count) begin
				count <= pwdata[7:0];
				block <= 1'b1;
			end else if (tick) begin
				count <= next_count;
				up    <= next_up;
				block <= 1'b0;
			end
		end
	end

	// flags, requests and pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags      <= 3'h0;
			irq_cmp_a  <= 1'b0;
			irq_ovf    <= 1'b0;
			irq_cmp_b  <= 1'b0;
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
			wave_oe_a  <= 1'b0;
			wave_oe_b  <= 1'b0;
		end else if (ce) begin
			flags      <= next_flags;
			irq_cmp_a  <= irq_req[tmr_pkg::IRQ_CMP_A];
			irq_ovf    <= irq_req[tmr_pkg::IRQ_OVF];
			irq_cmp_b  <= irq_req[tmr_pkg::IRQ_CMP_B];
			wave_out_a <= next_wa;
			wave_out_b <= next_wb;
			wave_oe_a  <= ctl_a.out_mode_a != tmr_pkg::OM_OFF;
			wave_oe_b  <= ctl_a.out_mode_b != tmr_pkg::OM_OFF;
		end
	end

endmodule // tmr_timer8
